// ===== design/mphp_pkg.sv
// Purpose: Shared constants and types for the modem parallel host port
// Assumes: 125 MHz clock, 16550A-style register map on three select lines
// Notes:   Times kept in their own unit, cycle counts derived here

package mphp_pkg;

    localparam int          CLK_MHZ        = 125;
    localparam int          READY_MS       = 25;
    localparam int          READY_CYCLES   = READY_MS * 1000 * CLK_MHZ;
    localparam int          CFG_LOAD_CYC   = 64;

    // Register indices selected by the three address lines
    localparam logic [2:0]  REG_DATA       = 3'h0;
    localparam logic [2:0]  REG_IRQ_EN     = 3'h1;
    localparam logic [2:0]  REG_IRQ_ID     = 3'h2;
    localparam logic [2:0]  REG_LINE_CTRL  = 3'h3;
    localparam logic [2:0]  REG_MDM_CTRL   = 3'h4;
    localparam logic [2:0]  REG_LINE_STAT  = 3'h5;
    localparam logic [2:0]  REG_MDM_STAT   = 3'h6;
    localparam logic [2:0]  REG_SCRATCH    = 3'h7;

    // Interrupt enable bit positions
    localparam int          IE_RX_DATA     = 0;
    localparam int          IE_THR_EMPTY   = 1;
    localparam int          IE_RX_ERR      = 2;
    localparam int          IE_MDM_STAT    = 3;

    // Interrupt identification codes, bit 0 high when none pending
    localparam logic [3:0]  IID_NONE       = 4'h1;
    localparam logic [3:0]  IID_RX_ERR     = 4'h6;
    localparam logic [3:0]  IID_RX_DATA    = 4'h4;
    localparam logic [3:0]  IID_THR_EMPTY  = 4'h2;
    localparam logic [3:0]  IID_MDM_STAT   = 4'h0;

    // Line status bit positions
    localparam int          LS_DATA_READY  = 0;
    localparam int          LS_OVERRUN     = 1;
    localparam int          LS_THR_EMPTY   = 5;
    localparam int          LS_TX_EMPTY    = 6;

    // Reset values
    localparam logic [7:0]  LCR_RESET      = 8'h03;
    localparam logic [7:0]  DEF_CFG        = 8'h00;

    typedef enum logic [1:0] {
        MPHP_RESET  = 2'b00,
        MPHP_LOAD   = 2'b01,
        MPHP_WAIT   = 2'b11,
        MPHP_READY  = 2'b10
    } mphp_state_type;

endpackage : mphp_pkg

// ===== design/mphp_strobe_if.sv
// Purpose: Carries decoded host strobes from the pin front end
// Assumes: All members synchronous to clk_i
// Notes:   Pulses last one clock

`timescale 1ns/100ps
`default_nettype none

interface mphp_strobe_if;
    logic       wr_pulse;
    logic       rd_pulse;
    logic       rd_active;
    logic [2:0] sel;
    logic [7:0] wdata;

    modport front (output wr_pulse, rd_pulse, rd_active, sel, wdata);
    modport core  (input  wr_pulse, rd_pulse, rd_active, sel, wdata);
endinterface : mphp_strobe_if

`default_nettype wire

// ===== design/mphp_front.sv
// Purpose: Registers host pins and turns strobes into one-clock pulses
// Assumes: Host pins synchronous to clk_i
// Notes:   Write taken at the rising edge of the write strobe

`timescale 1ns/100ps
`default_nettype none

module mphp_front (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        enable_i,
    input  wire logic        port_select_n_i,
    input  wire logic        port_write_n_i,
    input  wire logic        port_read_n_i,
    input  wire logic [2:0]  port_reg_sel_i,
    input  wire logic [7:0]  port_data_bus_i,
    mphp_strobe_if.front     st
);
    import mphp_pkg::*;

    logic       wr_q;
    logic       rd_q;
    logic [2:0] sel_q;
    logic [7:0] data_q;
    logic       wr_now;
    logic       rd_now;

    // Strobes count only with the port selected
    assign wr_now = enable_i && !port_select_n_i && !port_write_n_i;
    assign rd_now = enable_i && !port_select_n_i && !port_read_n_i;

    // Follow address and data while a write or read strobe is active, hold them after
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            sel_q  <= 3'h0;
            data_q <= 8'h00;
        end else begin
            wr_q <= wr_now;
            rd_q <= rd_now;
            if (wr_now || rd_now) begin
                sel_q  <= port_reg_sel_i;
                data_q <= port_data_bus_i;
            end
        end
    end

    assign st.wr_pulse  = wr_q && !wr_now;
    assign st.rd_pulse  = rd_q && !rd_now;
    assign st.rd_active = rd_now;
    assign st.sel       = rd_now ? port_reg_sel_i : sel_q;
    assign st.wdata     = data_q;

endmodule : mphp_front

`default_nettype wire

// ===== design/mphp_port.sv
// Purpose: Parallel host port of the modem controller, 16550A style
// Assumes: Host pins synchronous to clk_i; modem core feeds rx/tx events
// Notes:   Data bus is split into input, output and output enable

`timescale 1ns/100ps
`default_nettype none

module mphp_port #(
    parameter int READY_CYC = mphp_pkg::READY_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        iface_select_strap_i,
    input  wire logic        port_select_n_i,
    input  wire logic        port_write_n_i,
    input  wire logic        port_read_n_i,
    input  wire logic [2:0]  port_reg_sel_i,
    input  wire logic [7:0]  port_data_bus_i,
    output logic      [7:0]  port_data_bus_o,
    output logic      [7:0]  port_data_bus_oe_o,
    output logic             port_irq_out_o,
    input  wire logic        cfg_present_i,
    input  wire logic [7:0]  cfg_data_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_error_i,
    input  wire logic        tx_taken_i,
    input  wire logic [3:0]  modem_lines_i,
    output logic             tx_valid_o,
    output logic      [7:0]  tx_data_o,
    output logic      [7:0]  modem_ctrl_o,
    output logic             ready_o
);
    import mphp_pkg::*;

    // Ready delay must outlast the config load phase
    if (READY_CYC <= CFG_LOAD_CYC) begin : g_bad_ready
        $error("READY_CYC must exceed the config load time");
    end

    mphp_strobe_if st ();

    mphp_state_type state;
    logic [31:0]    cnt;
    logic           par_mode;
    logic [7:0]     rx_buf;
    logic           rx_ready;
    logic           rx_err;
    logic           thr_empty;
    logic           thr_irq;
    logic [3:0]     ms_q;
    logic [3:0]     ms_delta;
    logic [7:0]     ier;
    logic [7:0]     lcr;
    logic [7:0]     scr;
    logic [3:0]     iid;
    logic [7:0]     rd_val;
    logic           is_ready;

    assign is_ready = (state == MPHP_READY);

    mphp_front u_front (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .enable_i        (is_ready && par_mode),
        .port_select_n_i (port_select_n_i),
        .port_write_n_i  (port_write_n_i),
        .port_read_n_i   (port_read_n_i),
        .port_reg_sel_i  (port_reg_sel_i),
        .port_data_bus_i (port_data_bus_i),
        .st              (st)
    );

    // Highest pending source, line error first
    function automatic logic [3:0] pick_iid(input logic [7:0] en,
        input logic err, input logic rdy, input logic thr,
        input logic ms);
        if (en[IE_RX_ERR] && err)          pick_iid = IID_RX_ERR;
        else if (en[IE_RX_DATA] && rdy)    pick_iid = IID_RX_DATA;
        else if (en[IE_THR_EMPTY] && thr)  pick_iid = IID_THR_EMPTY;
        else if (en[IE_MDM_STAT] && ms)    pick_iid = IID_MDM_STAT;
        else                               pick_iid = IID_NONE;
    endfunction : pick_iid

    assign iid = pick_iid(ier, rx_err, rx_ready, thr_irq, |ms_delta);

    // Reset sequencing: config load, then ready delay
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= MPHP_RESET;
            cnt   <= 32'h0;
        end else begin
            case (state)
                MPHP_RESET: begin
                    state <= MPHP_LOAD;
                    cnt   <= 32'h0;
                end
                MPHP_LOAD: begin
                    if (cnt == 32'(CFG_LOAD_CYC - 1)) begin
                        state <= MPHP_WAIT;
                        cnt   <= 32'h0;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                MPHP_WAIT: begin
                    if (cnt >= 32'(READY_CYC - CFG_LOAD_CYC - 1)) begin
                        state <= MPHP_READY;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                default: state <= MPHP_READY;
            endcase
        end
    end

    // Strap caught after reset release
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            par_mode <= 1'b0;
        end else if (state == MPHP_RESET) begin
            par_mode <= iface_select_strap_i;
        end
    end

    // Configuration registers, restored on reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ier          <= 8'h00;
            lcr          <= LCR_RESET;
            scr          <= DEF_CFG;
            modem_ctrl_o <= DEF_CFG;
        end else if (state == MPHP_RESET) begin
            modem_ctrl_o <= cfg_present_i ? cfg_data_i : DEF_CFG;
        end else if (st.wr_pulse) begin
            case (st.sel)
                REG_IRQ_EN:    ier          <= {4'h0, st.wdata[3:0]};
                REG_LINE_CTRL: lcr          <= st.wdata;
                REG_MDM_CTRL:  modem_ctrl_o <= st.wdata;
                REG_SCRATCH:   scr          <= st.wdata;
                default: ;
            endcase
        end
    end

    // Transmit holding register and its empty interrupt
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o  <= 8'h00;
            thr_empty  <= 1'b1;
            thr_irq    <= 1'b0;
        end else if (st.wr_pulse && st.sel == REG_DATA) begin
            tx_data_o  <= st.wdata;
            tx_valid_o <= 1'b1;
            thr_empty  <= 1'b0;
            thr_irq    <= 1'b0;
        end else if (tx_valid_o && tx_taken_i) begin
            tx_valid_o <= 1'b0;
            thr_empty  <= 1'b1;
            thr_irq    <= 1'b1;
        end else if (st.rd_pulse && st.sel == REG_IRQ_ID
                     && iid == IID_THR_EMPTY) begin
            thr_irq <= 1'b0;
        end
    end

    // Receive buffer; new data wins over the read that clears it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_buf   <= 8'h00;
            rx_ready <= 1'b0;
            rx_err   <= 1'b0;
        end else begin
            if (rx_valid_i) begin
                rx_buf   <= rx_data_i;
                rx_ready <= 1'b1;
            end else if (st.rd_pulse && st.sel == REG_DATA) begin
                rx_ready <= 1'b0;
            end
            if (rx_error_i || (rx_valid_i && rx_ready)) begin
                rx_err <= 1'b1;
            end else if (st.rd_pulse && st.sel == REG_LINE_STAT) begin
                rx_err <= 1'b0;
            end
        end
    end

    // Modem status deltas, cleared by reading modem status
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ms_q     <= 4'h0;
            ms_delta <= 4'h0;
        end else begin
            ms_q <= modem_lines_i;
            if (st.rd_pulse && st.sel == REG_MDM_STAT) begin
                ms_delta <= ms_q ^ modem_lines_i;
            end else begin
                ms_delta <= ms_delta | (ms_q ^ modem_lines_i);
            end
        end
    end

    // Read mux
    always_comb begin
        if (st.sel == REG_DATA)           rd_val = rx_buf;
        else if (st.sel == REG_IRQ_EN)    rd_val = ier;
        else if (st.sel == REG_IRQ_ID)    rd_val = {4'h0, iid};
        else if (st.sel == REG_LINE_CTRL) rd_val = lcr;
        else if (st.sel == REG_MDM_CTRL)  rd_val = modem_ctrl_o;
        else if (st.sel == REG_LINE_STAT)
            rd_val = {1'b0, thr_empty && !tx_valid_o, thr_empty,
                      3'h0, rx_err, rx_ready};
        else if (st.sel == REG_MDM_STAT)  rd_val = {ms_q, ms_delta};
        else                              rd_val = scr;
    end

    // Data bus drive and interrupt output
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            port_data_bus_o    <= 8'h00;
            port_data_bus_oe_o <= 8'h00;
            port_irq_out_o     <= 1'b0;
            ready_o            <= 1'b0;
        end else begin
            port_data_bus_o    <= rd_val;
            port_data_bus_oe_o <= {8{st.rd_active}};
            port_irq_out_o     <= (iid != IID_NONE);
            ready_o            <= is_ready;
        end
    end

    // Cycles since reset release, saturating, for the ready-delay check
    logic [31:0] since_rel;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            since_rel <= 32'h0;
        end else if (since_rel != 32'hffff_ffff) begin
            since_rel <= since_rel + 32'h1;
        end
    end

    // Data bus only driven for a selected read, released right after
    a_bus_drive_sel: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        port_data_bus_oe_o != 8'h00
            |-> !$past(port_select_n_i) && !$past(port_read_n_i))
        else $error("bus driven without select and read");
    a_bus_release: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (port_select_n_i || port_read_n_i) |=> port_data_bus_oe_o == 8'h00)
        else $error("bus not released after read");

    // Interrupt line follows the pending sources
    a_irq_rx_data: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (rx_ready && ier[IE_RX_DATA]) |=> port_irq_out_o)
        else $error("rx data without interrupt");
    a_irq_none: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (iid == IID_NONE) |=> !port_irq_out_o)
        else $error("interrupt without source");
    a_rx_clear: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.rd_pulse && st.sel == REG_DATA && !rx_valid_i) |=> !rx_ready)
        else $error("rx data not cleared by read");

    // Reset and ready sequencing
    a_reset_idle: assert property (
        @(posedge clk_i)
        !rst_n_i |=> (state == MPHP_RESET && !port_irq_out_o))
        else $error("reset state not held");
    a_no_early_ready: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(is_ready) |-> cnt >= 32'(READY_CYC - CFG_LOAD_CYC - 1))
        else $error("ready too early");
    a_ready_delay: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(ready_o) |-> since_rel >= 32'(READY_CYC))
        else $error("ready before the delay ran out");
    a_not_ready_quiet: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !is_ready |=> port_data_bus_oe_o == 8'h00)
        else $error("bus driven before ready");

    // Register writes land, reads present the register
    a_write_stores: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.wr_pulse && st.sel == REG_SCRATCH) |=> scr == $past(st.wdata))
        else $error("scratch write lost");
    a_tx_load: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.wr_pulse && st.sel == REG_DATA)
            |=> tx_valid_o && tx_data_o == $past(st.wdata))
        else $error("transmit byte lost");
    a_read_data: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st.rd_active && st.sel == REG_SCRATCH)
            |=> port_data_bus_o == $past(scr))
        else $error("read value wrong");
    a_serial_quiet: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !par_mode |-> !st.wr_pulse && !st.rd_active)
        else $error("port active in serial mode");

endmodule : mphp_port

`default_nettype wire

// ===== tb/mphp_host_model.sv
// Purpose: Host bus master model driving the parallel port pins
// Assumes: Pins change 1 ns after the rising clock edge
// Notes:   Released data lines show the inverse of their last level

`timescale 1ns/100ps
`default_nettype none

module mphp_host_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  dout_i,
    input  wire logic [7:0]  oe_i,
    output logic             port_select_n_o,
    output logic             port_write_n_o,
    output logic             port_read_n_o,
    output logic      [2:0]  sel_o,
    output logic      [7:0]  bus_o
);
    logic       drv;
    logic [7:0] wdata;
    logic [7:0] last;

    initial begin
        port_select_n_o = 1'b1;
        port_write_n_o  = 1'b1;
        port_read_n_o   = 1'b1;
        sel_o           = 3'h0;
        wdata           = 8'h00;
        drv             = 1'b0;
        last            = 8'h00;
    end

    // Wire level from both parties; floating bus wanders
    assign bus_o = (oe_i == 8'hff) ? dout_i : (drv ? wdata : ~last);
    always @(posedge clk_i) begin
        last <= bus_o;
    end

    // Write cycle; address and data steady while strobe low
    task automatic write(input logic cs_n, input logic [2:0] sel,
                         input logic [7:0] d);
        @(posedge clk_i);
        #1;
        port_select_n_o = cs_n;
        port_write_n_o  = 1'b0;
        sel_o           = sel;
        wdata           = d;
        drv             = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        port_write_n_o  = 1'b1;
        @(posedge clk_i);
        #1;
        port_select_n_o = 1'b1;
        drv             = 1'b0;
    endtask : write

    // Read cycle; never overlaps a write strobe
    task automatic read(input logic [2:0] sel, output logic [7:0] d,
                        output logic [7:0] oe);
        @(posedge clk_i);
        #1;
        port_select_n_o = 1'b0;
        port_read_n_o   = 1'b0;
        sel_o           = sel;
        repeat (2) @(posedge clk_i);
        #1;
        d  = bus_o;
        oe = oe_i;
        port_read_n_o   = 1'b1;
        @(posedge clk_i);
        #1;
        port_select_n_o = 1'b1;
    endtask : read
endmodule : mphp_host_model

`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the modem parallel host port
// Assumes: Short ready delay through the READY_CYC parameter
// Notes:   Random payloads from a fixed seed

`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import mphp_pkg::*;
    localparam int RDY   = 100;
    localparam int LIMIT = 20000;

    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       strap = 1'b1;
    logic       cs_n, wr_n, rd_n;
    logic [2:0] sel;
    logic [2:0] rs;
    logic [7:0] bus, dout, oe, rd, roe, v, cfg, rxd;
    logic       irq, cfg_p, rx_v, rx_e, taken, tx_v, rdy;
    logic [3:0] mlines;
    logic [7:0] tx_d, mctrl;
    logic [3:0] codes [4];
    int         errors = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    int         rel = 0;

    always #4 clk_i = ~clk_i;

    mphp_host_model host_u (.clk_i(clk_i), .dout_i(dout), .oe_i(oe),
        .port_select_n_o(cs_n), .port_write_n_o(wr_n),
        .port_read_n_o(rd_n), .sel_o(sel), .bus_o(bus));

    mphp_port #(.READY_CYC(RDY)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .iface_select_strap_i(strap), .port_select_n_i(cs_n),
        .port_write_n_i(wr_n), .port_read_n_i(rd_n),
        .port_reg_sel_i(sel), .port_data_bus_i(bus),
        .port_data_bus_o(dout), .port_data_bus_oe_o(oe),
        .port_irq_out_o(irq), .cfg_present_i(cfg_p), .cfg_data_i(cfg),
        .rx_valid_i(rx_v), .rx_data_i(rxd), .rx_error_i(rx_e),
        .tx_taken_i(taken), .modem_lines_i(mlines), .tx_valid_o(tx_v),
        .tx_data_o(tx_d), .modem_ctrl_o(mctrl), .ready_o(rdy));

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            end_sim();
        end
    end

    // Reset held 8 cycles; host keeps it low long enough
    task automatic do_reset(input logic s);
        #1;
        rst_n_i = 1'b0;
        strap   = s;
        repeat (8) @(posedge clk_i);
        #1;
        chk("rst_irq", 8'h00, {7'h0, irq});
        chk("rst_oe", 8'h00, oe);
        rst_n_i = 1'b1;
        rel     = cyc;
    endtask : do_reset

    // Bounded wait for ready, counting from release
    task automatic wait_ready();
        while (rdy !== 1'b1 && cyc - rel < RDY + 200) begin
            @(posedge clk_i);
        end
        chk("ready_late", 8'h01, {7'h0, rdy});
        chk("ready_early", 8'h01, {7'h0, cyc - rel >= RDY});
        #1;
    endtask : wait_ready

    task automatic pulse(input int k);
        @(posedge clk_i);
        #1;
        if (k == 0) rx_v = 1'b1;
        if (k == 2) rx_e = 1'b1;
        if (k == 3) mlines = ~mlines;
        @(posedge clk_i);
        #1;
        rx_v = 1'b0;
        rx_e = 1'b0;
    endtask : pulse

    initial begin
        codes = '{IID_RX_DATA, IID_THR_EMPTY, IID_RX_ERR, IID_MDM_STAT};
        void'($urandom(33));
        cfg_p = 1'b1;
        cfg = 8'($urandom);
        rx_v = 1'b0;
        rx_e = 1'b0;
        taken = 1'b0;
        mlines = 4'($urandom);
        rxd = 8'h00;
        do_reset(1'b1);
        // Accesses before ready are refused
        host_u.write(1'b0, REG_SCRATCH, 8'h5a);
        host_u.read(REG_SCRATCH, rd, roe);
        chk("early_oe", 8'h00, roe);
        wait_ready();
        chk("cfg_load", cfg, mctrl);
        host_u.read(REG_LINE_CTRL, rd, roe);
        chk("lcr_rst", LCR_RESET, rd);
        // Random register traffic, plus writes with select high
        for (int i = 0; i < 12; i++) begin
            v = 8'($urandom) & 8'h7f;
            rs = (i % 3 == 0) ? REG_SCRATCH :
                 (i % 3 == 1) ? REG_LINE_CTRL : REG_MDM_CTRL;
            host_u.write(1'b0, rs, v);
            host_u.write(1'b1, rs, ~v);
            host_u.read(rs, rd, roe);
            chk("rd_oe", 8'hff, roe);
            chk("rd_val", v, rd);
            if (rs == REG_MDM_CTRL) chk("mcr_out", v, mctrl);
            repeat (2) @(posedge clk_i);
            chk("idle_oe", 8'h00, oe);
        end
        // Transmit byte reaches the core
        v = 8'($urandom);
        host_u.write(1'b0, REG_DATA, v);
        repeat (2) @(posedge clk_i);
        chk("tx_valid", 8'h01, {7'h0, tx_v});
        chk("tx_data", v, tx_d);
        #1 taken = 1'b1;
        @(posedge clk_i);
        #1 taken = 1'b0;
        chk("tx_done", 8'h00, {7'h0, tx_v});
        // Each interrupt source raised, identified and serviced
        for (int k = 0; k < 4; k++) begin
            rxd = 8'($urandom);
            host_u.write(1'b0, REG_IRQ_EN, 8'h01 << k);
            pulse(k);
            repeat (4) @(posedge clk_i);
            #1;
            chk("irq_set", 8'h01, {7'h0, irq});
            host_u.read(REG_IRQ_ID, rd, roe);
            chk("iid", {4'h0, codes[k]}, {4'h0, rd[3:0]});
            if (k == 0) host_u.read(REG_DATA, rd, roe);
            if (k == 0) chk("rx_byte", rxd, rd);
            if (k == 2) host_u.read(REG_LINE_STAT, rd, roe);
            if (k == 3) host_u.read(REG_MDM_STAT, rd, roe);
            repeat (3) @(posedge clk_i);
            #1;
            chk("irq_clr", 8'h00, {7'h0, irq});
            host_u.write(1'b0, REG_IRQ_EN, 8'h00);
        end
        // Master reset drops a pending interrupt; strap low refuses
        host_u.write(1'b0, REG_IRQ_EN, 8'h01);
        pulse(0);
        repeat (4) @(posedge clk_i);
        #1;
        chk("irq_pend", 8'h01, {7'h0, irq});
        do_reset(1'b0);
        repeat (RDY + 150) @(posedge clk_i);
        host_u.read(REG_SCRATCH, rd, roe);
        chk("serial_oe", 8'h00, roe);
        cfg_p = 1'b0;
        do_reset(1'b1);
        wait_ready();
        chk("cfg_dflt", DEF_CFG, mctrl);
        host_u.read(REG_LINE_CTRL, rd, roe);
        chk("lcr_again", LCR_RESET, rd);
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
